// *** common/msbs_pkg.sv ***
package msbs_pkg;
    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_STATUS_SELECT = 8'h00;
    localparam logic [7:0] OFS_SCRATCH = 8'h04;
    localparam logic [7:0] OFS_DIV_LOW = 8'h08;
    localparam logic [7:0] OFS_DIV_HIGH = 8'h0C;
    localparam logic [7:0] OFS_TX_FREE = 8'h10;
    localparam logic [7:0] OFS_RX_FILL = 8'h14;
    localparam logic [7:0] OFS_MODEM_CTRL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SEL_CNT_EN_BIT = 0;
    localparam int SEL_BANK_LSB = 1;
    localparam int MCR_LOOPBACK_BIT = 4;
    localparam int IRQ_LINE_BIT = 0;
    localparam int IRQ_RING_BIT = 1;

    // ************************************************************
    // bank codes and reset values
    // ************************************************************
    localparam logic [1:0] BANK_GENERAL = 2'h0;
    localparam logic [1:0] BANK_EXTRA1 = 2'h1;
    localparam logic [1:0] BANK_EXTRA2 = 2'h2;
    localparam logic [2:0] SELECT_RST = 3'h0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [4:0] MCR_RST = 5'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [3:0] PIN_IDLE_N = 4'hF;
endpackage : msbs_pkg

// *** common/msbs_modem_if.sv ***
`timescale 1ns/1ps
interface msbs_modem_if;
    logic [3:0] pin_n;   // raw pins: [3] cd, [2] ri, [1] dsr, [0] cts
    logic [3:0] level_n; // synchronised pin levels
    logic [3:0] change;  // one-cycle change pulses, same bit order; ri [2] pulses only on a rising pin
    modport det (input pin_n, output level_n, output change);
    modport user (output pin_n, input level_n, input change);
endinterface : msbs_modem_if

// *** design/msbs_edge_detect.sv ***
`timescale 1ns/1ps
module msbs_edge_detect
    import msbs_pkg::*;
(
    input wire logic pclk,    // device clock
    input wire logic presetn, // async reset, active low
    msbs_modem_if.det mif     // pins in, levels and change pulses out
);
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;
    logic [3:0] change_ff;

    // ************************************************************
    // two-stage synchroniser, then history stage
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= PIN_IDLE_N;
            sync2_ff <= PIN_IDLE_N;
            prev_ff <= PIN_IDLE_N;
        end else begin
            sync1_ff <= mif.pin_n;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // ************************************************************
    // change pulses
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_ff <= 4'h0;
        end else begin
            change_ff[3] <= sync2_ff[3] ^ prev_ff[3];
            change_ff[2] <= sync2_ff[2] & ~prev_ff[2];
            change_ff[1:0] <= sync2_ff[1:0] ^ prev_ff[1:0];
        end
    end

    assign mif.level_n = prev_ff;
    assign mif.change = change_ff;

    // ************************************************************
    // checks
    // ************************************************************
    a_ring_rise_only: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sync2_ff[2]) |=> !change_ff[2])
        else $error("ring flag pulsed on a falling pin");
endmodule : msbs_edge_detect

// *** design/msbs_top.sv ***
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module msbs_top
    import msbs_pkg::*;
(
    input wire logic pclk,                     // 40 MHz device clock
    input wire logic presetn,                  // async reset, active low
    input wire logic psel,                     // apb select
    input wire logic penable,                  // apb enable
    input wire logic pwrite,                   // apb direction
    input wire logic [ADDR_W-1:0] paddr,       // apb byte address
    input wire logic [DATA_W-1:0] pwdata,      // apb write data
    output logic [DATA_W-1:0] prdata,          // apb read data
    output logic pready,                       // apb ready
    output logic pslverr,                      // apb error, unmapped address
    input wire logic carrier_detect_in_n,      // modem pin, active low
    input wire logic ring_indicator_in_n,      // modem pin, active low
    input wire logic data_set_ready_in_n,      // modem pin, active low
    input wire logic clear_to_send_in_n,       // modem pin, active low
    input wire logic [7:0] tx_free_space_count, // free entries in tx fifo
    input wire logic [7:0] rx_fill_count,      // characters in rx fifo
    output logic [15:0] divisor_value,         // baud divisor
    output logic [1:0] bank_select,            // visible register bank
    output logic level_count_en,               // counters readable
    output logic loopback_mode,                // loopback active
    output logic modem_status_irq,             // modem status request
    output logic irq                           // masked interrupt, level
);
    // ************************************************************
    // declarations
    // ************************************************************
    logic [DATA_W-1:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] select_ff;
    logic level_en_ff;
    logic [3:0] flags_ff;
    logic [3:0] cap_flags_ff;
    logic [4:0] mcr_ff;
    logic [7:0] scratch_ff;
    logic [7:0] div_low_ff;
    logic [7:0] div_high_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_mask_ff;
    logic modem_irq_ff;
    logic irq_ff;
    logic [3:0] nxt_flags;
    logic [1:0] nxt_irq_status;
    logic [DATA_W-1:0] nxt_rdata;
    logic nxt_err;
    logic [3:0] status_hi;
    logic setup;
    logic wr_acc;
    logic rd_status_acc;

    msbs_modem_if mif();

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic counters_visible(input logic [2:0] sel);
        // a nonzero bank code hides the counters even with the enable set
        counters_visible = (sel[2:1] == BANK_GENERAL) && sel[SEL_CNT_EN_BIT];
    endfunction : counters_visible

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_STATUS_SELECT, OFS_SCRATCH, OFS_DIV_LOW, OFS_DIV_HIGH,
            OFS_TX_FREE, OFS_RX_FILL, OFS_MODEM_CTRL, OFS_IRQ_STATUS,
            OFS_IRQ_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // ************************************************************
    // modem pin synchroniser and edge detector
    // ************************************************************
    assign mif.pin_n = {carrier_detect_in_n, ring_indicator_in_n,
                        data_set_ready_in_n, clear_to_send_in_n};

    msbs_edge_detect u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .mif(mif.det)
    );

    // ************************************************************
    // apb phases
    // ************************************************************
    // read data is prepared in the setup cycle, so every access is zero-wait
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready_ff && pwrite;
    assign rd_status_acc = psel && penable && pready_ff && !pwrite &&
                           (paddr == OFS_STATUS_SELECT);

    always_comb begin
        if (mcr_ff[MCR_LOOPBACK_BIT]) begin
            status_hi = {mcr_ff[3], mcr_ff[2], mcr_ff[0], mcr_ff[1]};
        end else begin
            status_hi = ~mif.level_n;
        end
    end

    always_comb begin
        nxt_rdata = '0;
        nxt_err = !is_mapped(paddr);
        case (paddr)
            OFS_STATUS_SELECT: nxt_rdata[7:0] = {status_hi, flags_ff};
            OFS_SCRATCH: nxt_rdata[7:0] = scratch_ff;
            OFS_DIV_LOW: nxt_rdata[7:0] = div_low_ff;
            OFS_DIV_HIGH: nxt_rdata[7:0] = div_high_ff;
            OFS_TX_FREE: begin
                if (counters_visible(select_ff)) begin
                    nxt_rdata[7:0] = tx_free_space_count;
                end
            end
            OFS_RX_FILL: begin
                if (counters_visible(select_ff)) begin
                    nxt_rdata[7:0] = rx_fill_count;
                end
            end
            OFS_MODEM_CTRL: nxt_rdata[4:0] = mcr_ff;
            OFS_IRQ_STATUS: nxt_rdata[1:0] = irq_status_ff;
            OFS_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
            default: nxt_rdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
            cap_flags_ff <= FLAGS_RST;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup && nxt_err;
            if (setup && !pwrite) begin
                prdata_ff <= nxt_rdata;
                cap_flags_ff <= flags_ff;
            end
        end
    end

    // ************************************************************
    // modem change flags
    // ************************************************************
    // only the flags that were returned are cleared; a change between the
    // sample and the clear survives, and a same-cycle change wins
    always_comb begin
        nxt_flags = flags_ff;
        if (rd_status_acc) begin
            nxt_flags = flags_ff & ~cap_flags_ff;
        end
        nxt_flags = nxt_flags | mif.change;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAGS_RST;
            modem_irq_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            modem_irq_ff <= |nxt_flags;
        end
    end

    // ************************************************************
    // bank selector and software registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_ff <= SELECT_RST;
            level_en_ff <= 1'b0;
        end else if (wr_acc && paddr == OFS_STATUS_SELECT) begin
            select_ff <= pwdata[2:0];
            level_en_ff <= counters_visible(pwdata[2:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_ff <= BYTE_RST;
            div_low_ff <= BYTE_RST;
            div_high_ff <= BYTE_RST;
            mcr_ff <= MCR_RST;
        end else if (wr_acc) begin
            case (paddr)
                OFS_SCRATCH: scratch_ff <= pwdata[7:0];
                OFS_DIV_LOW: div_low_ff <= pwdata[7:0];
                OFS_DIV_HIGH: div_high_ff <= pwdata[7:0];
                OFS_MODEM_CTRL: mcr_ff <= pwdata[4:0];
                default: mcr_ff <= mcr_ff;
            endcase
        end
    end

    // ************************************************************
    // interrupt status and mask
    // ************************************************************
    always_comb begin
        nxt_irq_status = irq_status_ff;
        if (wr_acc && paddr == OFS_IRQ_STATUS) begin
            nxt_irq_status = irq_status_ff & ~pwdata[1:0];
        end
        nxt_irq_status[IRQ_LINE_BIT] = nxt_irq_status[IRQ_LINE_BIT] |
            mif.change[3] | mif.change[1] | mif.change[0];
        nxt_irq_status[IRQ_RING_BIT] = nxt_irq_status[IRQ_RING_BIT] | mif.change[2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_ff <= IRQ_RST;
            irq_mask_ff <= IRQ_RST;
            irq_ff <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            irq_ff <= |(nxt_irq_status & irq_mask_ff);
            if (wr_acc && paddr == OFS_IRQ_MASK) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign divisor_value = {div_high_ff, div_low_ff};
    assign bank_select = select_ff[2:1];
    assign level_count_en = level_en_ff;
    assign loopback_mode = mcr_ff[MCR_LOOPBACK_BIT];
    assign modem_status_irq = modem_irq_ff;
    assign irq = irq_ff;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_read_clears_flags: assert property (rd_status_acc && mif.change == 4'h0 &&
        flags_ff == cap_flags_ff |=> flags_ff == 4'h0)
        else $error("status read did not clear change flags");
    a_cd_normal_view: assert property (setup && !pwrite && paddr == OFS_STATUS_SELECT &&
        !loopback_mode |=> prdata[7] == !$past(mif.level_n[3]))
        else $error("carrier bit not inverted pin");
    a_ri_loop_view: assert property (setup && !pwrite && paddr == OFS_STATUS_SELECT &&
        loopback_mode |=> prdata[6] == $past(mcr_ff[2]))
        else $error("ring bit not control bit 2 in loopback");
    a_dsr_loop_view: assert property (setup && !pwrite && paddr == OFS_STATUS_SELECT &&
        loopback_mode |=> prdata[5] == $past(mcr_ff[0]))
        else $error("dsr bit not control bit 0 in loopback");
    a_cts_loop_view: assert property (setup && !pwrite && paddr == OFS_STATUS_SELECT &&
        loopback_mode |=> prdata[4] == $past(mcr_ff[1]))
        else $error("cts bit not control bit 1 in loopback");
    a_pin_change_flags: assert property ($changed(mif.level_n[3]) ##1 1'b1
        |-> flags_ff[3])
        else $error("carrier change flag not set");
    a_irq_on_change: assert property (mif.change != 4'h0 |=> modem_status_irq)
        else $error("modem status request missing");
    a_select_write: assert property (wr_acc && paddr == OFS_STATUS_SELECT
        |=> bank_select == $past(pwdata[2:1]) && flags_ff == $past(nxt_flags))
        else $error("selector write wrong or disturbed flags");
    a_counters_hidden: assert property (setup && !pwrite && paddr == OFS_TX_FREE &&
        (select_ff[2:1] != BANK_GENERAL || !select_ff[0]) |=> prdata == '0)
        else $error("hidden counter was readable");
    a_counter_read: assert property (setup && !pwrite && paddr == OFS_RX_FILL &&
        counters_visible(select_ff) |=> prdata[7:0] == $past(rx_fill_count))
        else $error("rx fill count wrong");
    a_scratch_hold: assert property (wr_acc && paddr == OFS_SCRATCH ##1
        !(wr_acc && paddr == OFS_SCRATCH)[*2] |-> scratch_ff == $past(pwdata[7:0], 2))
        else $error("scratch byte lost");
    a_divisor_low: assert property (wr_acc && paddr == OFS_DIV_LOW
        |=> divisor_value[7:0] == $past(pwdata[7:0]))
        else $error("divisor low byte not latched");
    a_set_wins_clear: assert property (rd_status_acc && mif.change[0] |=> flags_ff[0])
        else $error("change lost on status read");
    a_reset_values: assert property ($rose(presetn) |-> bank_select == BANK_GENERAL &&
        !level_count_en && flags_ff == FLAGS_RST)
        else $error("reset values wrong");

    c_flag_read: cover property (rd_status_acc && cap_flags_ff != 4'h0);
    c_loop_read: cover property (rd_status_acc && loopback_mode);
    c_counter_read: cover property (setup && paddr == OFS_TX_FREE && level_count_en);
    c_irq_raised: cover property ($rose(irq));
endmodule : msbs_top

// *** dv/msbs_modem_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// modem side: drives the four active-low status pins
// ************************************************************
module msbs_modem_model (
    input wire logic pclk,        // device clock
    input wire logic [3:0] want_n, // wanted pins: cd, ri, dsr, cts
    input wire logic slow,        // apply changes one cycle late
    output logic cd_n,            // carrier pin
    output logic ri_n,            // ring pin
    output logic dsr_n,           // data set ready pin
    output logic cts_n            // clear to send pin
);
    logic [3:0] late_ff;

    // pins are always driven; a slow modem lags its own intent
    always_ff @(posedge pclk) begin
        late_ff <= want_n;
    end
    assign {cd_n, ri_n, dsr_n, cts_n} = slow ? late_ff : want_n;
endmodule : msbs_modem_model

// *** dv/test_modem_status_and_bank_select.sv ***
`timescale 1ns/1ps
module test_modem_status_and_bank_select;
    import msbs_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, en;
    logic cd_n, ri_n, dsr_n, cts_n, lcen, lpbk, msirq, irq;
    logic [7:0] paddr, tx_cnt, rx_cnt;
    logic [31:0] pwdata, prdata, rnd;
    logic [3:0] want_n, fl;
    logic [15:0] div;
    logic [1:0] bank;
    logic [32:0] exp_q[$];
    int errors, checks, cycles;

    always #12.5 pclk = ~pclk;

    msbs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .carrier_detect_in_n(cd_n),
        .ring_indicator_in_n(ri_n), .data_set_ready_in_n(dsr_n),
        .clear_to_send_in_n(cts_n), .tx_free_space_count(tx_cnt),
        .rx_fill_count(rx_cnt), .divisor_value(div), .bank_select(bank),
        .level_count_en(lcen), .loopback_mode(lpbk), .modem_status_irq(msirq),
        .irq(irq));

    msbs_modem_model modem (.pclk(pclk), .want_n(want_n), .slow(slow), .cd_n(cd_n),
        .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    // expected {pslverr, prdata} is queued before the request goes out
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    // ************************************************************
    // monitor and hang guard
    // ************************************************************
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        end
        cycles++;
        if (cycles == 6000) begin
            errors++;
            test_done();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        want_n = 4'hF;
        tx_cnt = 8'h00;
        rx_cnt = 8'h00;
        rnd = 32'h520C8E85;
        errors = 0;
        checks = 0;
        cycles = 0;
        step(12);
        presetn <= 1'b1;
        step(1);
        check({bank, lcen, div}, 33'h0);
        rd(OFS_STATUS_SELECT, 32'h0);
        rnd = lfsr(rnd);
        wr(OFS_SCRATCH, {24'h0, rnd[7:0]});
        wr(OFS_DIV_LOW, {24'h0, rnd[15:8]});
        wr(OFS_DIV_HIGH, {24'h0, rnd[23:16]});
        rd(OFS_SCRATCH, {24'h0, rnd[7:0]});
        rd(OFS_DIV_LOW, {24'h0, rnd[15:8]});
        rd(OFS_DIV_HIGH, {24'h0, rnd[23:16]});
        check(div, rnd[23:8]);
        apb(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h40, rnd, {1'b1, 32'h0});
        // bank codes with junk in the reserved bits
        for (int s = 0; s < 8; s++) begin
            rnd = lfsr(rnd);
            tx_cnt <= rnd[7:0];
            rx_cnt <= rnd[15:8];
            wr(OFS_STATUS_SELECT, {24'h0, rnd[23:19], s[2:0]});
            en = (s[2:1] == 2'b00) && s[0];
            check({bank, lcen}, {s[2:1], en});
            wr(OFS_TX_FREE, rnd);
            rd(OFS_TX_FREE, en ? {24'h0, rnd[7:0]} : 32'h0);
            rd(OFS_RX_FILL, en ? {24'h0, rnd[15:8]} : 32'h0);
            rd(OFS_STATUS_SELECT, 32'h0);
        end
        wr(OFS_STATUS_SELECT, 32'h0);
        // one pin at a time, prompt and slow modem alternating
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            want_n[i] <= 1'b0;
            step(8);
            fl = (i == 2) ? 4'h0 : 4'h1 << i;
            check(msirq, fl != 4'h0);
            if (i == 0) begin
                check(irq, 1'b0);
                wr(OFS_IRQ_MASK, 32'h3);
            end
            rd(OFS_STATUS_SELECT, {24'h0, 4'h1 << i, fl});
            rd(OFS_STATUS_SELECT, {24'h0, 4'h1 << i, 4'h0});
            want_n[i] <= 1'b1;
            step(8);
            rd(OFS_IRQ_STATUS, (i == 2) ? 32'h2 : 32'h1);
            check(irq, 1'b1);
            rd(OFS_STATUS_SELECT, {24'h0, 4'h0, 4'h1 << i});
            wr(OFS_IRQ_STATUS, 32'h3);
            step(2);
            check({irq, msirq}, 33'h0);
        end
        // cts edge lands on the clearing edge of a status read
        slow <= 1'b0;
        want_n[0] <= 1'b0;
        step(8);
        want_n[0] <= 1'b1;
        step(2);
        rd(OFS_STATUS_SELECT, 32'h11);
        rd(OFS_STATUS_SELECT, 32'h01);
        // loopback shows control bits, no change flags from it
        for (int c = 0; c < 16; c++) begin
            wr(OFS_MODEM_CTRL, 32'h10 | c);
            check(lpbk, 1'b1);
            rd(OFS_STATUS_SELECT, {24'h0, c[3], c[2], c[0], c[1], 4'h0});
        end
        wr(OFS_MODEM_CTRL, 32'h0);
        step(2);
        check({lpbk, msirq}, 33'h0);
        test_done();
    end
endmodule : test_modem_status_and_bank_select
